/* rtl/gain_offset_pkg.sv */
// constants for the per-channel digital gain / offset register slice
// assumes a classic wishbone slave with 32-bit data and byte addresses
package gain_offset_pkg;
  // ************************************************
  // bus geometry
  // ************************************************
  localparam int ADR_W  = 8;
  localparam int DAT_W  = 32;
  localparam int SEL_W  = 4;
  localparam int REG_W  = 16;
  localparam int NCHAN  = 3;

  // ************************************************
  // register indices, byte address is index times four
  // ************************************************
  localparam logic [5:0] IDX_GLOBAL_CTRL = 6'h03;
  localparam logic [5:0] IDX_STATUS      = 6'h30;
  // channels 10, 11, 12 in that order
  localparam logic [5:0] CH_GO_IDX [0:NCHAN-1] = '{6'h27, 6'h29, 6'h2B};
  localparam logic [5:0] CH_OC_IDX [0:NCHAN-1] = '{6'h28, 6'h2A, 6'h2C};

  // ************************************************
  // field layout and reset values
  // ************************************************
  localparam int GAIN_LSB     = 11;
  localparam int GAIN_W       = 5;
  localparam int OFFS_W       = 10;
  localparam int GAIN_EN_BIT  = 12;
  localparam int OFFS_EN_BIT  = 8;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

  // ************************************************
  // gain coefficient format: unsigned, 14 fraction bits
  // ************************************************
  localparam int COEF_W    = 16;
  localparam int GAIN_FRAC = 14;
  localparam logic [COEF_W-1:0] COEF_UNITY = 16'h4000;
endpackage

/* rtl/chan_digital_gain_offset_regs.sv */
// gain and offset control registers for output channels 10..12 plus the datapath they steer
// assumes: wishbone classic master on clk_i, channel samples synchronous to clk_i
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps

// Behaviour
// RULE_01: gain field N gives N times 0.2 dB
// RULE_02: gain applied only while global gain enabled
// RULE_03: offset is signed ten bits, added
// RULE_04: offset applied only while global offset enabled
// RULE_05: host writes channel 10 offset in both
// RULE_06: host writes channel 11 offset in both
// RULE_07: host writes channel 12 offset in both
// RULE_08: channel 11 at 29h, channel 12 at 2Bh
// RULE_09: all fields reset to zero
// RULE_10: host writes zero to reserved bits
module chan_digital_gain_offset_regs
#(
  parameter int DATA_W = 14
)
(
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                cyc_i,
  input  wire logic                                stb_i,
  input  wire logic                                we_i,
  input  wire logic [gain_offset_pkg::ADR_W-1:0]   adr_i,
  input  wire logic [gain_offset_pkg::SEL_W-1:0]   sel_i,
  input  wire logic [gain_offset_pkg::DAT_W-1:0]   dat_i,
  output logic      [gain_offset_pkg::DAT_W-1:0]   dat_o,
  output logic                                     ack_o,
  input  wire logic                                data_valid_i,
  input  wire logic signed [DATA_W-1:0]            chan10_data_i,
  input  wire logic signed [DATA_W-1:0]            chan11_data_i,
  input  wire logic signed [DATA_W-1:0]            chan12_data_i,
  output logic                                     data_valid_o,
  output logic signed [DATA_W-1:0]                 chan10_data_o,
  output logic signed [DATA_W-1:0]                 chan11_data_o,
  output logic signed [DATA_W-1:0]                 chan12_data_o
);
  import gain_offset_pkg::*;

  localparam int PROD_W = DATA_W + COEF_W + 1;
  localparam int SUM_W  = PROD_W + 1;
  // signed bounds; an unsigned bound would clip every negative sum to full scale
  localparam logic signed [SUM_W-1:0] SAT_HI = SUM_W'(2 ** (DATA_W - 1) - 1);
  localparam logic signed [SUM_W-1:0] SAT_LO = -SAT_HI - SUM_W'(1);

  // ************************************************
  // register storage
  // ************************************************
  logic [REG_W-1:0]         go_r [0:NCHAN-1];
  logic [REG_W-1:0]         oc_r [0:NCHAN-1];
  logic                     global_digital_gain_enable_r;
  logic                     global_digital_offset_enable_r;
  logic                     ack_r;
  logic [DAT_W-1:0]         rdata_r;
  logic [DAT_W-1:0]         rdata_nxt;
  logic                     req;
  logic                     wr_now;
  logic [5:0]               idx;
  logic [NCHAN-1:0]         mismatch;
  logic signed [DATA_W-1:0] din   [0:NCHAN-1];
  logic signed [DATA_W-1:0] dout_r [0:NCHAN-1];
  logic                     valid_r;

  // ************************************************
  // helpers
  // ************************************************
  // byte-lane merge; only the two low lanes hold register bits
  function automatic logic [REG_W-1:0] merge16
  (
    input logic [REG_W-1:0] old_v,
    input logic [DAT_W-1:0] new_v,
    input logic [SEL_W-1:0] sel
  );
    logic [REG_W-1:0] res;
    res = old_v;
    if (sel[0])
    begin
      res[7:0] = new_v[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  // linear factor 10^(N*0.2/20) with 14 fraction bits; a table avoids a log unit
  function automatic logic [COEF_W-1:0] gain_coef(input logic [GAIN_W-1:0] n);
    logic [COEF_W-1:0] c;
    c = COEF_UNITY;
    unique case (n)
      5'h00: c = 16'h4000;
      5'h01: c = 16'h417E;
      5'h02: c = 16'h4304;
      5'h03: c = 16'h4494;
      5'h04: c = 16'h462D;
      5'h05: c = 16'h47CF;
      5'h06: c = 16'h497B;
      5'h07: c = 16'h4B32;
      5'h08: c = 16'h4CF2;
      5'h09: c = 16'h4EBD;
      5'h0A: c = 16'h5092;
      5'h0B: c = 16'h5273;
      5'h0C: c = 16'h545F;
      5'h0D: c = 16'h5656;
      5'h0E: c = 16'h5858;
      5'h0F: c = 16'h5A67;
      5'h10: c = 16'h5C82;
      5'h11: c = 16'h5EAA;
      5'h12: c = 16'h60DE;
      5'h13: c = 16'h6320;
      5'h14: c = 16'h656F;
      5'h15: c = 16'h67CC;
      5'h16: c = 16'h6A37;
      5'h17: c = 16'h6CB0;
      5'h18: c = 16'h6F38;
      5'h19: c = 16'h71CF;
      5'h1A: c = 16'h7476;
      5'h1B: c = 16'h772D;
      5'h1C: c = 16'h79F3;
      5'h1D: c = 16'h7CCA;
      5'h1E: c = 16'h7FB2;
      5'h1F: c = 16'h82AC;
    endcase
    return c;
  endfunction

  // ************************************************
  // bus decode
  // ************************************************
  // the write lands on the edge where the master samples ack
  assign req    = cyc_i & stb_i;
  assign wr_now = req & we_i & ack_r;
  assign idx    = adr_i[7:2];

  // ************************************************
  // wishbone acknowledge: one wait cycle, then ack for one cycle
  // ************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= req & ~ack_r;
    end
  end

  // ************************************************
  // per-channel register writes
  // ************************************************
  // RULE_08: channel register placement
  // RULE_09: zero reset
  always_ff @(posedge clk_i)
  begin
    for (int c = 0; c < NCHAN; c++)
    begin
      if (rst_i)
      begin
        go_r[c] <= REG_RESET;
        oc_r[c] <= REG_RESET;
      end
      else if (wr_now && idx == CH_GO_IDX[c])
      begin
        go_r[c] <= merge16(go_r[c], dat_i, sel_i);
      end
      else if (wr_now && idx == CH_OC_IDX[c])
      begin
        oc_r[c] <= merge16(oc_r[c], dat_i, sel_i);
      end
    end
  end

  // ************************************************
  // global enables
  // ************************************************
  // RULE_09: enables clear on reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      global_digital_gain_enable_r   <= 1'b0;
      global_digital_offset_enable_r <= 1'b0;
    end
    else if (wr_now && idx == IDX_GLOBAL_CTRL)
    begin
      if (sel_i[1])
      begin
        global_digital_gain_enable_r   <= dat_i[GAIN_EN_BIT];
        global_digital_offset_enable_r <= dat_i[OFFS_EN_BIT];
      end
    end
  end

  // ************************************************
  // read mux
  // ************************************************
  // status shows which channels hold differing offset copies
  always_comb
  begin
    for (int c = 0; c < NCHAN; c++)
    begin
      mismatch[c] = go_r[c][OFFS_W-1:0] != oc_r[c][OFFS_W-1:0];
    end
  end

  // unmapped indices read zero and ignore writes
  always_comb
  begin
    rdata_nxt = '0;
    if (idx == IDX_GLOBAL_CTRL)
    begin
      rdata_nxt[GAIN_EN_BIT] = global_digital_gain_enable_r;
      rdata_nxt[OFFS_EN_BIT] = global_digital_offset_enable_r;
    end
    if (idx == IDX_STATUS)
    begin
      rdata_nxt[NCHAN-1:0] = mismatch;
    end
    for (int c = 0; c < NCHAN; c++)
    begin
      if (idx == CH_GO_IDX[c])
      begin
        rdata_nxt[REG_W-1:0] = go_r[c];
      end
      if (idx == CH_OC_IDX[c])
      begin
        rdata_nxt[REG_W-1:0] = oc_r[c];
      end
    end
  end

  // read data is captured with the ack so it is valid exactly then
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_r <= '0;
    end
    else if (req && !ack_r)
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // ************************************************
  // datapath: gain then offset, saturated, one register stage
  // ************************************************
  assign din[0] = chan10_data_i;
  assign din[1] = chan11_data_i;
  assign din[2] = chan12_data_i;

  for (genvar g = 0; g < NCHAN; g++)
  begin : g_chan
    logic [COEF_W-1:0]       coef;
    logic signed [PROD_W-1:0] prod;
    logic signed [SUM_W-1:0]  sum;
    logic signed [SUM_W-1:0]  offs;
    logic signed [DATA_W-1:0] sat;

    // RULE_01: gain lookup
    // RULE_02: gain enable gate
    assign coef = global_digital_gain_enable_r ? gain_coef(go_r[g][GAIN_LSB +: GAIN_W]) : COEF_UNITY;
    assign prod = PROD_W'(din[g] * $signed({1'b0, coef}));

    // RULE_03: signed offset add
    // RULE_04: offset enable gate
    assign offs = global_digital_offset_enable_r ? SUM_W'($signed(go_r[g][OFFS_W-1:0])) : '0;
    assign sum  = SUM_W'(prod >>> GAIN_FRAC) + offs;

    // clip rather than wrap, a wrapped sample looks like a huge echo
    always_comb
    begin
      if (sum > SAT_HI)
      begin
        sat = {1'b0, {(DATA_W-1){1'b1}}};
      end
      else if (sum < SAT_LO)
      begin
        sat = {1'b1, {(DATA_W-1){1'b0}}};
      end
      else
      begin
        sat = sum[DATA_W-1:0];
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        dout_r[g] <= '0;
      end
      else if (data_valid_i)
      begin
        dout_r[g] <= sat;
      end
    end
  end

  // valid is registered on the same edge that loads the sample register, so a new sample and valid appear together
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= data_valid_i;
    end
  end

  // ************************************************
  // outputs, all straight from flops
  // ************************************************
  assign ack_o         = ack_r;
  assign dat_o         = rdata_r;
  assign data_valid_o  = valid_r;
  assign chan10_data_o = dout_r[0];
  assign chan11_data_o = dout_r[1];
  assign chan12_data_o = dout_r[2];

endmodule

/* dv/gain_offset_monitor.sv */
// port checker for the channel gain / offset register slice
// assumes a classic wishbone master and one clock, bound to the top module
`timescale 1ns/1ps
module gain_offset_monitor
#(
  parameter int DATA_W = 14
)
(
  input wire logic                              clk_i,
  input wire logic                              rst_i,
  input wire logic                              cyc_i,
  input wire logic                              stb_i,
  input wire logic                              we_i,
  input wire logic [gain_offset_pkg::ADR_W-1:0] adr_i,
  input wire logic [gain_offset_pkg::SEL_W-1:0] sel_i,
  input wire logic [gain_offset_pkg::DAT_W-1:0] dat_i,
  input wire logic [gain_offset_pkg::DAT_W-1:0] dat_o,
  input wire logic                              ack_o,
  input wire logic                              data_valid_i,
  input wire logic                              data_valid_o,
  input wire logic signed [DATA_W-1:0]          chan11_data_i,
  input wire logic signed [DATA_W-1:0]          chan11_data_o,
  input wire logic signed [DATA_W-1:0]          chan10_data_o
);
  import gain_offset_pkg::*;
  logic en_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // one-bit shadow of the global enables, set while either of the two is on
  // ****
  // a write lands on the edge where ack is seen high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_r <= 1'b0;
    else if (cyc_i && stb_i && we_i && ack_o && adr_i[7:2] == IDX_GLOBAL_CTRL && sel_i[1])
      en_r <= dat_i[GAIN_EN_BIT] || dat_i[OFFS_EN_BIT];
  end
  // ****
  // assertions
  // ****
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_read_upper_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000) else $error("upper read bits set");
  a_unmapped_reads_zero: assert property (ack_o && $past(!we_i && adr_i[7:2] == 6'h3F) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_valid_one_late: assert property (data_valid_i |=> data_valid_o) else $error("valid not delayed");
  a_idle_holds_data: assert property (!data_valid_i |=> !data_valid_o && $stable(chan10_data_o))
    else $error("output moved without valid");
  a_bypass_when_off: assert property (data_valid_i && !en_r |=> chan11_data_o == $past(chan11_data_i))
    else $error("data altered with enables off");
endmodule

bind chan_digital_gain_offset_regs gain_offset_monitor #(.DATA_W(DATA_W)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .data_valid_i(data_valid_i), .data_valid_o(data_valid_o),
  .chan11_data_i(chan11_data_i), .chan11_data_o(chan11_data_o), .chan10_data_o(chan10_data_o));

/* dv/tb.sv */
// self-checking bench for the channel gain / offset register slice
// assumes wishbone classic answers and a one-cycle datapath latency
`timescale 1ns/1ps
module tb;
  import gain_offset_pkg::*;
  localparam int DW = 14;
  logic                 clk_i, rst_i, cyc_i, stb_i, we_i, data_valid_i, ack_o, data_valid_o, gen, oen;
  logic [ADR_W-1:0]     adr_i;
  logic [SEL_W-1:0]     sel_i;
  logic [DAT_W-1:0]     dat_i, dat_o, rd;
  logic signed [DW-1:0] din [3];
  logic signed [DW-1:0] dout [3];
  logic [4:0]           gn [3];
  logic [9:0]           of [3];
  int                   errors, num_checks, seed;

  chan_digital_gain_offset_regs #(.DATA_W(DW)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .data_valid_i(data_valid_i), .chan10_data_i(din[0]),
    .chan11_data_i(din[1]), .chan12_data_i(din[2]), .data_valid_o(data_valid_o), .chan10_data_o(dout[0]),
    .chan11_data_o(dout[1]), .chan12_data_o(dout[2]));

  // ****
  // helpers
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hF;
    dat_i <= d;
    // only the watchdog ends a wait that never sees ack
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    check(ack_o, 1'b1);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  // expected sample: gain coefficient rounded, floor shift, then saturate
  function automatic logic signed [DW-1:0] model(input logic signed [DW-1:0] x, input int c);
    longint v;
    v = gen ? (longint'(x) * $rtoi(16384.0 * 10.0 ** (gn[c] * 0.01) + 0.5)) >>> 14 : longint'(x);
    if (oen)
      v += longint'($signed(of[c]));
    if (v > 2 ** (DW - 1) - 1)
      v = 2 ** (DW - 1) - 1;
    if (v < -(2 ** (DW - 1)))
      v = -(2 ** (DW - 1));
    return v[DW-1:0];
  endfunction

  task automatic sample();
    @(posedge clk_i);
    data_valid_i <= 1'b1;
    for (int c = 0; c < 3; c++)
      din[c] <= DW'($random(seed));
    @(posedge clk_i);
    data_valid_i <= 1'b0;
    #1;
    check(data_valid_o, 1'b1);
    for (int c = 0; c < 3; c++)
      check(dout[c], model(din[c], c));
  endtask

  // same offset in both, reserved bits zero
  task automatic setch(input int c, input logic [4:0] g, input logic [9:0] o);
    gn[c] = g;
    of[c] = o;
    wb(1'b1, CH_GO_IDX[c], {16'h0, g, 1'b0, o});
    wb(1'b1, CH_OC_IDX[c], {22'h0, o});
    rchk(CH_GO_IDX[c], {16'h0, g, 1'b0, o});
    rchk(CH_OC_IDX[c], {22'h0, o});
  endtask

  // registers and outputs cleared by reset
  task automatic zeros();
    gen = 1'b0;
    oen = 1'b0;
    rchk(IDX_GLOBAL_CTRL, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      gn[c] = 5'h0;
      of[c] = 10'h0;
      check(dout[c], 32'h0);
      rchk(CH_GO_IDX[c], 32'h0);
      rchk(CH_OC_IDX[c], 32'h0);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****
  // clock, watchdog, main sequence
  // ****
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // far beyond the couple of hundred cycles the sequence needs
  initial
  begin
    #500000;
    errors++;
    complete_run();
  end

  initial
  begin
    {cyc_i, stb_i, we_i, data_valid_i} = 4'h0;
    adr_i = '0;
    sel_i = '0;
    dat_i = '0;
    din = '{default: '0};
    seed = 2;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    zeros();
    setch(0, 5'h1F, 10'h1FF);
    setch(1, 5'h00, 10'h200);
    setch(2, 5'($random(seed)), 10'($random(seed)));
    rchk(IDX_STATUS, 32'h0);
    // every enable combination, off first so settings must be ignored
    for (int m = 0; m < 4; m++)
    begin
      gen = m[1];
      oen = m[0];
      wb(1'b1, IDX_GLOBAL_CTRL, {19'h0, gen, 3'h0, oen, 8'h00});
      rchk(IDX_GLOBAL_CTRL, {19'h0, gen, 3'h0, oen, 8'h00});
      repeat (6) sample();
    end
    wb(1'b1, 6'h3F, $random(seed));
    rchk(6'h3F, 32'h0);
    // second reset in mid-run with everything enabled
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    zeros();
    repeat (3) sample();
    complete_run();
  end
endmodule
